//--- src/spp_top.sv
// Purpose: Input linearizer, setpoint clamp, output rate limiter, program control
// Assumes: AHB-Lite zero-wait slave; measured input and fault synchronous to clk
// Notes:   One program timing tick per second; faster ticks via TICK_CYC
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`include "spp_defines.svh"
`default_nettype none
module spp_top
   import spp_pkg::*;
#(
   parameter int TICK_CYC = `SPP_TICK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic signed [15:0] measIn,
   input wire logic inputFault,
   input wire logic powerRestored,
   input wire spp_pair_s ctrlDemand,
   output spp_pair_s controlOutput,
   output logic signed [15:0] linearValue,
   output logic signed [15:0] fixSetpoint,
   output logic signed [15:0] startSetpoint,
   output logic signed [15:0] stepSetpoint,
   output logic [2:0] overLimit,
   output logic runLamp,
   output logic [8:0] stepNumber,
   output logic patternReinit,
   output logic [8:0] ch1StepCap,
   output logic [8:0] ch2StepCap
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic signed [15:0] clampSv(input logic signed [15:0] v,
      input logic signed [15:0] lo, input logic signed [15:0] hi);
      if (v < lo) return lo;
      if (v > hi) return hi;
      return v;
   endfunction

   // Hours/minutes or minutes/seconds pair to seconds
   function automatic logic [19:0] toSec(input logic [15:0] hm, input logic unitMs);
      logic [19:0] hiPart;
      logic [19:0] loPart;
      hiPart = {12'h000, hm[15:8]};
      loPart = {12'h000, hm[7:0]};
      if (unitMs) return 20'(hiPart * 20'd60 + loPart);
      return 20'(hiPart * 20'd3600 + loPart * 20'd60);
   endfunction

   function automatic logic timeOk(input logic [31:0] w);
      return w[15:8] <= `SPP_HH_MAX && w[7:0] <= `SPP_MM_MAX;
   endfunction

   function automatic logic ptOk(input logic [31:0] w);
      return $signed(w[15:0]) >= `SPP_PT_MIN && $signed(w[15:0]) <= `SPP_PT_MAX;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus slave

   spp_ctrl_s ctrl_q;
   spp_state_e state_q;
   logic signed [15:0] svLow_q, svHigh_q, svFix_q, svStart_q, svStep_q;
   logic [15:0] rate1_q, rate2_q, err1_q, err2_q;
   logic [15:0] delay_q, skip_q, stepLen_q;
   logic [8:0] numSteps_q;
   logic [4:0] ch1Pat_q;
   logic signed [15:0] linA_q [`SPP_LIN_POINTS];
   logic signed [15:0] linB_q [`SPP_LIN_POINTS];
   logic [7:0] dAddr_q;
   logic dWrite_q;
   logic [31:0] hrdata_q;
   logic [2:0] cmd;
   logic wr;
   logic addrPhase;
   logic [7:0] aAddr;
   logic [31:0] rdMux;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign addrPhase = hsel && hready && htrans[1];
   assign aAddr = {haddr[7:2], 2'b00};
   assign wr = dWrite_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         dWrite_q <= 1'b0;
         dAddr_q <= 8'h00;
      end else if (hready) begin
         dWrite_q <= addrPhase && hwrite;
         dAddr_q <= aAddr;
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (aAddr)
         `SPP_REG_CTRL: rdMux = {24'h000000, ctrl_q};
         `SPP_REG_STAT: rdMux = {12'h000, stepNumber, 4'h0, overLimit, inputFault, runLamp, state_q};
         `SPP_REG_SVLIM: rdMux = {svHigh_q, svLow_q};
         `SPP_REG_RATE: rdMux = {rate2_q, rate1_q};
         `SPP_REG_ERRV: rdMux = {err2_q, err1_q};
         `SPP_REG_DELAY: rdMux = {16'h0000, delay_q};
         `SPP_REG_SKIP: rdMux = {16'h0000, skip_q};
         `SPP_REG_PAT: rdMux = {ch2StepCap, ch1StepCap, 9'h000, ch1Pat_q};
         `SPP_REG_STEP: rdMux = {7'h00, numSteps_q, stepLen_q};
         `SPP_REG_SVFIX: rdMux = {16'h0000, svFix_q};
         `SPP_REG_SVSTART: rdMux = {16'h0000, svStart_q};
         `SPP_REG_SVSTEP: rdMux = {16'h0000, svStep_q};
         `SPP_REG_LINOUT: rdMux = {{16{linearValue[15]}}, linearValue};
         default: begin
            for (int i = 0; i < `SPP_LIN_POINTS; i++) begin
               if (aAddr == 8'(`SPP_REG_LINA + 4 * i)) rdMux = {16'h0000, linA_q[i]};
               if (aAddr == 8'(`SPP_REG_LINB + 4 * i)) rdMux = {16'h0000, linB_q[i]};
            end
         end
      endcase
   end

   // Read data taken at the address phase, stands through the data phase
   always_ff @(posedge clk) begin
      if (rst) hrdata_q <= 32'h0000_0000;
      else if (addrPhase && !hwrite) hrdata_q <= rdMux;
   end

   assign cmd = (wr && dAddr_q == `SPP_REG_CMD) ? hwdata[2:0] : 3'h0;

   // Writes outside the documented range are ignored; setpoints and the step count are stored as written
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= '0;
         svLow_q <= `SPP_SV_LO;
         svHigh_q <= `SPP_SV_HI;
         rate1_q <= 16'h0000;
         rate2_q <= 16'h0000;
         err1_q <= 16'h0000;
         err2_q <= 16'h0000;
         delay_q <= 16'h0000;
         skip_q <= 16'h0000;
         stepLen_q <= 16'h0001;
         numSteps_q <= 9'h014;
         svFix_q <= `SPP_SV_LO;
         svStart_q <= `SPP_SV_LO;
         svStep_q <= `SPP_SV_LO;
      end else if (wr) begin
         unique case (dAddr_q)
            `SPP_REG_CTRL: begin
               if (hwdata[5:4] != 2'h3) ctrl_q.faultAct <= hwdata[5:4];
               ctrl_q.inType <= hwdata[1:0];
               ctrl_q.linOn <= hwdata[2];
               ctrl_q.powerResume <= hwdata[6];
               ctrl_q.skipTime <= hwdata[7];
               if (state_q == ST_RESET) ctrl_q.unitMs <= hwdata[3];
            end
            `SPP_REG_SVLIM: begin
               if ($signed(hwdata[15:0]) < $signed(hwdata[31:16]) && $signed(hwdata[15:0]) >= `SPP_SV_LO
                   && $signed(hwdata[31:16]) <= `SPP_SV_HI) begin
                  svLow_q <= hwdata[15:0];
                  svHigh_q <= hwdata[31:16];
               end
            end
            `SPP_REG_RATE: begin
               if (hwdata[15:0] <= `SPP_RATE_MAX) rate1_q <= hwdata[15:0];
               if (hwdata[31:16] <= `SPP_RATE_MAX) rate2_q <= hwdata[31:16];
            end
            `SPP_REG_ERRV: begin
               if (hwdata[15:0] <= `SPP_OUT_MAX) err1_q <= hwdata[15:0];
               if (hwdata[31:16] <= `SPP_OUT_MAX) err2_q <= hwdata[31:16];
            end
            `SPP_REG_DELAY: if (timeOk(hwdata)) delay_q <= hwdata[15:0];
            `SPP_REG_SKIP: if (timeOk(hwdata)) skip_q <= hwdata[15:0];
            `SPP_REG_STEP: begin
               if (timeOk(hwdata)) stepLen_q <= hwdata[15:0];
               numSteps_q <= hwdata[24:16];
            end
            `SPP_REG_SVFIX: svFix_q <= hwdata[15:0];
            `SPP_REG_SVSTART: svStart_q <= hwdata[15:0];
            `SPP_REG_SVSTEP: svStep_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `SPP_LIN_POINTS; i++) begin
            linA_q[i] <= `SPP_PT_RST;
            linB_q[i] <= `SPP_PT_RST;
         end
      end else if (wr && ptOk(hwdata)) begin
         for (int i = 0; i < `SPP_LIN_POINTS; i++) begin
            if (dAddr_q == 8'(`SPP_REG_LINA + 4 * i)) linA_q[i] <= hwdata[15:0];
            if (dAddr_q == 8'(`SPP_REG_LINB + 4 * i)) linB_q[i] <= hwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pattern allotment

   always_ff @(posedge clk) begin
      if (rst) begin
         ch1Pat_q <= `SPP_PAT_RST;
         patternReinit <= 1'b0;
      end else begin
         patternReinit <= 1'b0;
         if (wr && dAddr_q == `SPP_REG_PAT && state_q == ST_RESET && hwdata[4:0] <= `SPP_PAT_TOTAL) begin
            ch1Pat_q <= hwdata[4:0];
            patternReinit <= hwdata[4:0] != ch1Pat_q;
         end
      end
   end

   assign ch1StepCap = 9'(ch1Pat_q * `SPP_STEPS_PER_PAT);
   assign ch2StepCap = 9'((`SPP_PAT_TOTAL - ch1Pat_q) * `SPP_STEPS_PER_PAT);

   ////////////////////////////////////////////////////////////////////////
   // Setpoint clamp

   always_comb begin
      fixSetpoint = clampSv(svFix_q, svLow_q, svHigh_q);
      startSetpoint = clampSv(svStart_q, svLow_q, svHigh_q);
      stepSetpoint = clampSv(svStep_q, svLow_q, svHigh_q);
      overLimit = {stepSetpoint != svStep_q, startSetpoint != svStart_q, fixSetpoint != svFix_q};
   end

   ////////////////////////////////////////////////////////////////////////
   // Linearizer

   int nValid;
   logic stopScan;
   logic [3:0] seg;
   logic signed [31:0] num, den;
   logic linActive;

   always_comb begin
      nValid = 1;
      stopScan = 1'b0;
      seg = 4'h0;
      for (int i = 1; i < `SPP_LIN_POINTS; i++) begin
         if (!stopScan && linA_q[i] > linA_q[i - 1]) nValid = i + 1;
         else stopScan = 1'b1;
      end
      // First and last segments extend beyond the table ends
      for (int i = 1; i < `SPP_LIN_POINTS - 1; i++) begin
         if (i < nValid - 1 && measIn >= linA_q[i]) seg = 4'(i);
      end
      num = 32'(measIn - linA_q[seg]) * 32'(linB_q[seg + 4'd1] - linB_q[seg]);
      den = 32'(linA_q[seg + 4'd1] - linA_q[seg]);
      linActive = ctrl_q.linOn && !ctrl_q.inType[1] && nValid >= 2;
   end

   always_ff @(posedge clk) begin
      if (rst) linearValue <= 16'sh0000;
      else if (linActive) linearValue <= 16'(linB_q[seg] + 16'(num / den));
      else linearValue <= measIn;
   end

   ////////////////////////////////////////////////////////////////////////
   // Timing tick

   logic [31:0] tickCnt_q;
   logic tick;
   logic blink_q;

   assign tick = tickCnt_q == 32'(TICK_CYC - 1);

   always_ff @(posedge clk) begin
      if (rst) tickCnt_q <= 32'h0000_0000;
      else if (tick) tickCnt_q <= 32'h0000_0000;
      else tickCnt_q <= tickCnt_q + 32'h0000_0001;
   end

   always_ff @(posedge clk) begin
      if (rst) blink_q <= 1'b0;
      else if (tick) blink_q <= !blink_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Program control

   logic [19:0] delayLeft_q, stepLeft_q, skipSec;
   logic faultHold;

   assign skipSec = toSec(skip_q, ctrl_q.unitMs);
   assign faultHold = inputFault && spp_fault_e'(ctrl_q.faultAct) == FLT_HOLD;
   assign runLamp = state_q == ST_DELAY ? blink_q : state_q != ST_RESET;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_RESET;
         delayLeft_q <= 20'h00000;
         stepLeft_q <= 20'h00000;
         stepNumber <= 9'h000;
      end else if (cmd[`SPP_CMD_RESET]) begin
         state_q <= ST_RESET;
      end else if (powerRestored && !ctrl_q.powerResume) begin
         state_q <= ST_RESET;
      end else if (state_q != ST_RESET && inputFault && spp_fault_e'(ctrl_q.faultAct) == FLT_RESET) begin
         state_q <= ST_RESET;
      end else begin
         // Resume keeps every program register as it stands
         unique case (state_q)
            ST_RESET: begin
               if (cmd[`SPP_CMD_START] && numSteps_q != 9'h000) begin
                  state_q <= ST_DELAY;
                  delayLeft_q <= toSec(delay_q, 1'b0);
                  stepNumber <= 9'h001;
                  stepLeft_q <= toSec(stepLen_q, ctrl_q.unitMs);
               end
            end
            ST_DELAY: begin
               if (delayLeft_q == 20'h00000) state_q <= ST_RUN;
               else if (tick) delayLeft_q <= delayLeft_q - 20'h00001;
            end
            ST_RUN, ST_HOLD: begin
               state_q <= faultHold ? ST_HOLD : ST_RUN;
               if (cmd[`SPP_CMD_SKIP] && !ctrl_q.skipTime) begin
                  stepLeft_q <= 20'h00000;
               end else if (cmd[`SPP_CMD_SKIP] && skipSec != 20'h00000) begin
                  stepLeft_q <= skipSec >= stepLeft_q ? 20'h00000 : stepLeft_q - skipSec;
               end else if (stepLeft_q == 20'h00000) begin
                  if (stepNumber >= numSteps_q) begin
                     state_q <= ST_RESET;
                  end else begin
                     stepNumber <= stepNumber + 9'h001;
                     stepLeft_q <= toSec(stepLen_q, ctrl_q.unitMs);
                  end
               end else if (tick && !faultHold && state_q == ST_RUN) begin
                  stepLeft_q <= stepLeft_q - 20'h00001;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output fault value and rate limiter

   function automatic logic [15:0] rateStep(input logic [15:0] cur, input logic [15:0] tgt,
      input logic [15:0] rate);
      if (rate == 16'h0000) return tgt;
      if (tgt > cur) return (tgt - cur > rate) ? 16'(cur + rate) : tgt;
      return (cur - tgt > rate) ? 16'(cur - rate) : tgt;
   endfunction

   spp_pair_s target;

   always_comb begin
      target.first = inputFault ? err1_q : ctrlDemand.first;
      target.second = inputFault ? err2_q : ctrlDemand.second;
      if (target.first > `SPP_OUT_MAX) target.first = `SPP_OUT_MAX;
      if (target.second > `SPP_OUT_MAX) target.second = `SPP_OUT_MAX;
   end

   // Rate applies once per one-second tick, so its 0.1 %/s unit is the step size
   always_ff @(posedge clk) begin
      if (rst) begin
         controlOutput <= '0;
      end else if (tick || rate1_q == 16'h0000 || rate2_q == 16'h0000) begin
         if (tick || rate1_q == 16'h0000)
            controlOutput.first <= rateStep(controlOutput.first, target.first, rate1_q);
         if (tick || rate2_q == 16'h0000)
            controlOutput.second <= rateStep(controlOutput.second, target.second, rate2_q);
      end
   end

endmodule
`default_nettype wire

//--- src/spp_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes:   Percent values in 0.01 % (points, clamps) or 0.1 % (outputs)
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH
`define SPP_CLK_HZ 20000000
`define SPP_TICK_S 1
`define SPP_TICK_CYC (`SPP_CLK_HZ * `SPP_TICK_S)
`define SPP_REG_CTRL 8'h00
`define SPP_REG_CMD 8'h04
`define SPP_REG_STAT 8'h08
`define SPP_REG_SVLIM 8'h0c
`define SPP_REG_RATE 8'h10
`define SPP_REG_ERRV 8'h14
`define SPP_REG_DELAY 8'h18
`define SPP_REG_SKIP 8'h1c
`define SPP_REG_PAT 8'h20
`define SPP_REG_STEP 8'h24
`define SPP_REG_SVFIX 8'h28
`define SPP_REG_SVSTART 8'h2c
`define SPP_REG_SVSTEP 8'h30
`define SPP_REG_LINOUT 8'h34
`define SPP_REG_LINA 8'h40
`define SPP_REG_LINB 8'h80
`define SPP_LIN_POINTS 11
`define SPP_PT_MIN (-16'sd500)
`define SPP_PT_MAX 16'sd10500
`define SPP_PT_RST 16'sd0
`define SPP_SV_LO 16'sd0
`define SPP_SV_HI 16'sd10000
`define SPP_RATE_MAX 16'd1000
`define SPP_OUT_MAX 16'd1000
`define SPP_HH_MAX 8'd99
`define SPP_MM_MAX 8'd59
`define SPP_PAT_TOTAL 5'd20
`define SPP_PAT_RST 5'd10
`define SPP_STEPS_PER_PAT 9'd20
`define SPP_CMD_START 0
`define SPP_CMD_RESET 1
`define SPP_CMD_SKIP 2
`endif

//--- src/spp_pkg.sv
// Purpose: Types shared by the setpoint/program processing block
// Assumes: Constants come from spp_defines.svh
// Notes:   Control word layout matches the CTRL register low byte
`default_nettype none
package spp_pkg;
   typedef enum logic [1:0] {ST_RESET, ST_DELAY, ST_RUN, ST_HOLD} spp_state_e;
   typedef enum logic [1:0] {FLT_HOLD, FLT_RUN, FLT_RESET} spp_fault_e;
   typedef struct packed {
      logic skipTime;
      logic powerResume;
      logic [1:0] faultAct;
      logic unitMs;
      logic linOn;
      logic [1:0] inType;
   } spp_ctrl_s;
   typedef struct packed {
      logic [15:0] second;
      logic [15:0] first;
   } spp_pair_s;
endpackage
`default_nettype wire

//--- verif/spp_asserts.sv
// Purpose: Port-level properties of spp_top
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every spp_top instance
`default_nettype none
module spp_asserts
   import spp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire spp_pair_s controlOutput,
   input wire logic signed [15:0] linearValue,
   input wire logic signed [15:0] fixSetpoint,
   input wire logic signed [15:0] startSetpoint,
   input wire logic signed [15:0] stepSetpoint,
   input wire logic runLamp,
   input wire logic patternReinit,
   input wire logic [8:0] ch1StepCap,
   input wire logic [8:0] ch2StepCap
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   sequence s_pulse;
      patternReinit ##1 !patternReinit;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait OKAY");
   a_fix_clamp: assert property (fixSetpoint >= 16'sh0 && fixSetpoint <= 16'sh2710)
      else $error("fixed setpoint outside range");
   a_sv_clamp: assert property (startSetpoint >= 16'sh0 && startSetpoint <= 16'sh2710
      && stepSetpoint >= 16'sh0 && stepSetpoint <= 16'sh2710)
      else $error("program setpoint outside range");
   a_cap_sum: assert property (ch1StepCap + ch2StepCap == 9'h190)
      else $error("step capacities do not share 400");
   a_cap_steps: assert property (ch1StepCap <= 9'h190 && ch1StepCap % 9'h014 == 9'h0)
      else $error("channel one capacity not a pattern multiple");
   a_reinit_once: assert property (patternReinit |-> s_pulse)
      else $error("reinit pulse longer than one cycle");
   // Catches state left over from before the reset
   a_reset_quiet: assert property ($fell(rst) |-> !runLamp && controlOutput == 32'h0
      && linearValue == 16'sh0)
      else $error("outputs not idle after reset");
   a_out_range: assert property (controlOutput.first <= 16'h03e8 && controlOutput.second <= 16'h03e8)
      else $error("control output above full scale");
endmodule
bind spp_top spp_asserts u_chk (.clk, .rst, .hreadyout, .hresp, .controlOutput, .linearValue,
   .fixSetpoint, .startSetpoint, .stepSetpoint, .runLamp, .patternReinit, .ch1StepCap, .ch2StepCap);
`default_nettype wire

//--- verif/spp_plant_model.sv
// Purpose: Sensor card and demand source ahead of the block
// Assumes: Bench sets the requested levels
// Notes:   Levels re-timed to clk, as a sampling input card would
`default_nettype none
module spp_plant_model
   import spp_pkg::*;
(
   input wire logic clk,
   input wire logic signed [15:0] measReq,
   input wire logic faultReq,
   input wire spp_pair_s demandReq,
   output logic signed [15:0] measIn = 16'sh0,
   output logic inputFault = 1'b0,
   output spp_pair_s ctrlDemand = 32'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clk) begin
      measIn <= measReq;
      inputFault <= faultReq;
      ctrlDemand <= demandReq;
   end
endmodule
`default_nettype wire

//--- verif/tb_setpoint_program_processing.sv
// Purpose: Self-checking bench for the setpoint and program block
// Assumes: Zero-wait bus, tick shortened to 10 clocks
// Notes:   One task per scenario, run in order
`default_nettype none
module tb_setpoint_program_processing
   import spp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic faultReq = 1'b0;
   logic powerRestored = 1'b0;
   logic reinitSeen = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rdData;
   logic signed [15:0] measReq = 16'sh0;
   spp_pair_s demandReq = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, inputFault, runLamp, patternReinit;
   logic signed [15:0] measIn, linearValue, fixSetpoint, startSetpoint, stepSetpoint;
   spp_pair_s ctrlDemand, controlOutput;
   logic [2:0] overLimit;
   logic [8:0] stepNumber, ch1StepCap, ch2StepCap;
   int num_errors = 0;
   int cmp_count = 0;
   always #25 clk = ~clk;
   always @(posedge clk) if (patternReinit) reinitSeen <= 1'b1;
   spp_plant_model plant (.clk, .measReq, .faultReq, .demandReq, .measIn, .inputFault, .ctrlDemand);
   spp_top #(.TICK_CYC(10)) uut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .measIn, .inputFault, .powerRestored,
      .ctrlDemand, .controlOutput, .linearValue, .fixSetpoint, .startSetpoint, .stepSetpoint,
      .overLimit, .runLamp, .stepNumber, .patternReinit, .ch1StepCap, .ch2StepCap);
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rdData = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdData & m, e);
   endtask
   // Polls the state field; read data lags by one cycle so poll, never sample once
   task automatic waitSt(input logic [1:0] s, input int n);
      rdData = {30'h0, ~s};
      repeat (n) if (rdData[1:0] !== s) xfer(1'b0, 8'h08, 32'h0);
      chk(rdData[1:0], s);
   endtask
   task automatic power;
      powerRestored <= 1'b1;
      @(posedge clk);
      powerRestored <= 1'b0;
   endtask
   task automatic meas(input logic signed [15:0] v, input logic signed [15:0] e);
      measReq <= v;
      cyc(4);
      chk(linearValue, e);
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      rdchk(8'h00, 32'hff, 32'h0);
      rdchk(8'h0c, 32'hffffffff, 32'h27100000);
      rdchk(8'h10, 32'hffffffff, 32'h0);
      rdchk(8'h18, 32'hffff, 32'h0);
      rdchk(8'h1c, 32'hffff, 32'h0);
      rdchk(8'h68, 32'hffff, 32'h0);
      rdchk(8'h20, 32'hffffc01f, {9'hc8, 9'hc8, 9'h0, 5'ha});
      rdchk(8'hfc, 32'hffffffff, 32'h0);
   endtask
   task automatic t_lin;
      xfer(1'b1, 8'h00, 32'h4);
      xfer(1'b1, 8'h44, 32'h2710);
      xfer(1'b1, 8'h84, 32'h1388);
      xfer(1'b1, 8'h48, 32'h1388);
      xfer(1'b1, 8'h88, 32'h2328);
      xfer(1'b1, 8'h4c, 32'h2905);
      rdchk(8'h4c, 32'hffff, 32'h0);
      meas(16'h07d0, 16'h03e8);
      meas(16'hfe70, 16'hff38);
      meas(16'h28a0, 16'h1450);
      xfer(1'b1, 8'h00, 32'h6);
      meas(16'h07d0, 16'h07d0);
      xfer(1'b1, 8'h00, 32'h5);
      meas(16'h07d0, 16'h03e8);
      xfer(1'b1, 8'h00, 32'h0);
   endtask
   task automatic t_clamp;
      xfer(1'b1, 8'h0c, 32'h1f4003e8);
      xfer(1'b1, 8'h28, 32'h2328);
      xfer(1'b1, 8'h2c, 32'h01f4);
      xfer(1'b1, 8'h30, 32'h0bb8);
      cyc(1);
      chk(fixSetpoint, 32'h1f40);
      chk(startSetpoint, 32'h03e8);
      chk(stepSetpoint, 32'h0bb8);
      chk(overLimit, 32'h3);
      xfer(1'b1, 8'h0c, 32'h03e803e8);
      rdchk(8'h0c, 32'hffffffff, 32'h1f4003e8);
   endtask
   task automatic t_out;
      xfer(1'b1, 8'h10, 32'ha);
      demandReq <= {16'h00c8, 16'h01f4};
      cyc(35);
      chk(controlOutput.first inside {[16'h14:16'h28]}, 32'h1);
      chk(controlOutput.second, 32'hc8);
      xfer(1'b1, 8'h14, 32'h007b0000);
      faultReq <= 1'b1;
      cyc(4);
      chk(controlOutput.second, 32'h7b);
      faultReq <= 1'b0;
      xfer(1'b1, 8'h10, 32'h3e9);
      rdchk(8'h10, 32'hffffffff, 32'ha);
   endtask
   task automatic t_prog;
      longint t0;
      logic lamp;
      xfer(1'b1, 8'h00, 32'h8);
      xfer(1'b1, 8'h24, 32'h0002001e);
      xfer(1'b1, 8'h18, 32'h1);
      xfer(1'b1, 8'h04, 32'h1);
      t0 = $time;
      waitSt(2'h1, 3);
      lamp = runLamp;
      cyc(10);
      chk(runLamp, {31'h0, ~lamp});
      waitSt(2'h2, 200);
      chk((($time - t0) / 50) inside {[580:640]}, 32'h1);
      cyc(3);
      chk(runLamp, 32'h1);
      xfer(1'b1, 8'h00, 32'h0);
      rdchk(8'h00, 32'h8, 32'h8);
      xfer(1'b1, 8'h20, 32'h3);
      rdchk(8'h20, 32'h1f, 32'ha);
      chk(stepNumber, 32'h1);
      xfer(1'b1, 8'h04, 32'h4);
      cyc(2);
      chk(stepNumber, 32'h2);
      faultReq <= 1'b1;
      waitSt(2'h3, 5);
      faultReq <= 1'b0;
      waitSt(2'h2, 5);
      xfer(1'b1, 8'h00, 32'h10);
      faultReq <= 1'b1;
      cyc(4);
      rdchk(8'h08, 32'h3, 32'h2);
      faultReq <= 1'b0;
      xfer(1'b1, 8'h00, 32'h50);
      power;
      rdchk(8'h08, 32'h3, 32'h2);
      xfer(1'b1, 8'h00, 32'h20);
      faultReq <= 1'b1;
      waitSt(2'h0, 5);
      faultReq <= 1'b0;
      xfer(1'b1, 8'h00, 32'h88);
      xfer(1'b1, 8'h18, 32'h0);
      xfer(1'b1, 8'h04, 32'h1);
      waitSt(2'h2, 5);
      xfer(1'b1, 8'h04, 32'h4);
      cyc(2);
      chk(stepNumber, 32'h1);
      xfer(1'b1, 8'h1c, 32'h32);
      xfer(1'b1, 8'h04, 32'h4);
      cyc(2);
      chk(stepNumber, 32'h2);
      xfer(1'b1, 8'h00, 32'h8);
      power;
      waitSt(2'h0, 5);
   endtask
   // Last: a zero allotment would leave channel one no steps to run
   task automatic t_pat;
      // No allotment change before this point, so the flag is still clear
      xfer(1'b1, 8'h20, 32'h5);
      cyc(2);
      chk(reinitSeen, 32'h1);
      chk(ch1StepCap, 32'h64);
      chk(ch2StepCap, 32'h12c);
      xfer(1'b1, 8'h20, 32'h15);
      rdchk(8'h20, 32'h1f, 32'h5);
      xfer(1'b1, 8'h20, 32'h0);
      cyc(1);
      chk(ch1StepCap, 32'h0);
      chk(ch2StepCap, 32'h190);
   endtask
   task automatic conclude;
      $display("errors %0d, compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_lin;
      t_clamp;
      t_out;
      t_prog;
      t_pat;
      conclude;
   end
   initial begin
      #2000000;
      num_errors++;
      conclude;
   end
endmodule
`default_nettype wire
